// file: rtl/adc_pins_map.svh
// register map, field positions and reset values of the pin logic
`ifndef ADC_PINS_MAP_SVH
`define ADC_PINS_MAP_SVH
// ------------------------------------------------------------
// register select codes (comms register field)
// ------------------------------------------------------------
`define SEL_STATUS 3'h0
`define SEL_MODE 3'h1
`define SEL_CONFIG 3'h2
`define SEL_DATA 3'h3
`define SEL_ID 3'h4
`define SEL_GPOCON 3'h5
// ------------------------------------------------------------
// fields and widths
// ------------------------------------------------------------
`define COMMS_BITS 5'h08
`define SHORT_BITS 5'h08
`define LONG_BITS 5'h18
`define COMMS_READ_BIT 6
`define COMMS_SEL_HI 5
`define COMMS_SEL_LO 3
`define CFG_REF_SELECT_BIT 20
`define STATUS_RDY_BIT 7
`define GPO_HI 3
`define GPO_LO 0
// ------------------------------------------------------------
// reset values; id value is arbitrary
// ------------------------------------------------------------
`define ZERO_WORD 24'h000000
`define MODE_RESET 24'h080060
`define CONFIG_RESET 24'h000117
`define ID_VALUE 24'h0000A5
`define GPO_RESET 24'h000000
`define COUNT_ZERO 5'h00
`define COUNT_ONE 5'h01
`endif

// file: rtl/adc_pins_pkg.sv
// types shared by the serial, ready and output-pin logic
package adc_pins_pkg;
   // serial transfer phase, one bit changes command->write, two bits change command->read
   typedef enum logic [1:0] {
      PH_CMD = 2'b00,
      PH_WRITE = 2'b01,
      PH_READ = 2'b11
   } phase_e;

   // serial pins after synchronisation
   typedef struct packed {
      logic cs_n;
      logic sclk;
      logic din;
   } link_s;

   // one shared output pin: level and active-low enable
   typedef struct packed {
      logic level;
      logic oe_n;
   } pin_drive_s;

   typedef logic [23:0] word_t;
endpackage

// file: rtl/adc_serial_pins.sv
// serial interface, ready pin, filter sync and output pins of the converter
//
// Operation
// - while filter sync is low the filter, its control, calibration and modulator are held in reset.
// - filter sync leaves the serial interface alone but forces a low ready indication back high.
// - the shared output/ready pin goes low when a completed conversion is loaded, which waits for chip select high.
// - an unread result has its ready indication returned high before the next result update.
// - with chip select low output bits change on the falling clock edge and the host samples on the rising edge.
// - the output shift register loads from any selected on-chip register so a read returns it.
// - serial input bits are transferred to the register addressed by the comms register select field.
// - four pins are general-purpose outputs driven from register contents, by default including the shared two.
// - with the reference source select bit at 1 the two shared pins stop driving and serve as second reference inputs.
`include "adc_pins_map.svh"
module adc_serial_pins
   import adc_pins_pkg::*;
(
   input wire logic sys_clk, // system clock, 50 MHz
   input wire logic reset_n, // synchronous reset, active low
   input wire logic cs_n, // chip select pin, async
   input wire logic sclk, // serial clock pin, async
   input wire logic din, // serial data in pin, async
   input wire logic sync_n, // filter sync pin, async
   input wire logic [23:0] sample_data, // conversion result
   input wire logic sample_valid, // result offered
   output logic sample_ready, // buffer can accept
   output logic dout_rdy, // serial out / ready pin
   output logic filter_reset, // filter, control, calibration reset
   output logic modulator_reset, // modulator held in reset
   output logic gpo_bit3, // general-purpose output 3
   output logic gpo_bit2, // general-purpose output 2
   output logic gpo1_or_second_ref_pos, // output 1 level
   output logic gpo1_or_second_ref_pos_oe_n, // low while driving
   output logic gpo0_or_second_ref_neg, // output 0 level
   output logic gpo0_or_second_ref_neg_oe_n, // low while driving
   output logic reference_source_select // second reference chosen
);

   // ------------------------------------------------------------
   // functions
   // ------------------------------------------------------------
   // number of data bits a register takes on the wire
   function automatic logic [4:0] reg_bits(input logic [2:0] sel);
      logic [4:0] n;
      n = `SHORT_BITS;
      if (sel == `SEL_MODE || sel == `SEL_CONFIG || sel == `SEL_DATA)
         n = `LONG_BITS;
      return n;
   endfunction

   // ------------------------------------------------------------
   // synchronisers
   // ------------------------------------------------------------
   link_s link_meta, link_s1, link_s2;
   logic sync_meta, sync_s;

   // two stages before any logic looks at the pins
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         link_meta <= '{cs_n: 1'b1, sclk: 1'b1, din: 1'b0};
         link_s1 <= '{cs_n: 1'b1, sclk: 1'b1, din: 1'b0};
         link_s2 <= '{cs_n: 1'b1, sclk: 1'b1, din: 1'b0};
         sync_meta <= 1'b1;
         sync_s <= 1'b1;
      end else begin
         link_meta <= '{cs_n: cs_n, sclk: sclk, din: din};
         link_s1 <= link_meta;
         link_s2 <= link_s1;
         sync_meta <= sync_n;
         sync_s <= sync_meta;
      end
   end

   logic sclk_rise, sclk_fall, active;
   assign active = !link_s1.cs_n;
   assign sclk_rise = active && link_s1.sclk && !link_s2.sclk;
   assign sclk_fall = active && !link_s1.sclk && link_s2.sclk;

   // ------------------------------------------------------------
   // filter sync
   // ------------------------------------------------------------
   // hold in reset
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         filter_reset <= 1'b1;
         modulator_reset <= 1'b1;
      end else begin
         filter_reset <= !sync_s;
         modulator_reset <= !sync_s;
      end
   end

   // ------------------------------------------------------------
   // two-entry result buffer
   // ------------------------------------------------------------
   word_t buf_mem [2];
   logic buf_wr, buf_rd;
   logic [1:0] buf_count;
   logic buf_valid, buf_pop, buf_push;

   assign buf_valid = buf_count != 2'h0;
   assign buf_push = sample_valid && sample_ready;

   // stale results flushed so conversion restarts fresh
   always_ff @(posedge sys_clk) begin
      if (!reset_n || !sync_s) begin
         buf_wr <= 1'b0;
         buf_rd <= 1'b0;
         buf_count <= 2'h0;
         sample_ready <= 1'b0;
      end else begin
         if (buf_push) begin
            buf_mem[buf_wr] <= sample_data;
            buf_wr <= !buf_wr;
         end
         if (buf_pop)
            buf_rd <= !buf_rd;
         case ({buf_push, buf_pop})
            2'b10: buf_count <= buf_count + 2'h1;
            2'b01: buf_count <= buf_count - 2'h1;
            default: buf_count <= buf_count;
         endcase
         // ready registered: full after this cycle means stall
         sample_ready <= (buf_count == 2'h0)
            || (buf_count == 2'h1 && !(buf_push && !buf_pop))
            || (buf_count == 2'h2 && buf_pop);
      end
   end

   // ------------------------------------------------------------
   // serial transfer state
   // ------------------------------------------------------------
   phase_e phase;
   logic [4:0] bit_count;
   logic [4:0] width;
   word_t in_shift, out_shift;
   logic [2:0] sel, cmd_sel;
   logic read_done, write_done;
   word_t mode_reg, config_reg, data_reg, gpo_reg;
   logic rdy_n;

   assign width = reg_bits(sel);
   assign cmd_sel = in_shift[`COMMS_SEL_HI - 1:`COMMS_SEL_LO - 1];
   assign write_done = phase == PH_WRITE && sclk_rise
      && bit_count == width - `COUNT_ONE;
   assign read_done = phase == PH_READ && sclk_rise
      && bit_count == width - `COUNT_ONE;

   // selected register as the output shifter sees it
   function automatic word_t reg_value(input logic [2:0] s);
      word_t v;
      v = `ZERO_WORD;
      unique case (s)
         `SEL_STATUS: v[`STATUS_RDY_BIT] = rdy_n;
         `SEL_MODE: v = mode_reg;
         `SEL_CONFIG: v = config_reg;
         `SEL_DATA: v = data_reg;
         `SEL_ID: v = `ID_VALUE;
         `SEL_GPOCON: v = gpo_reg;
         default: v = `ZERO_WORD;
      endcase
      return v;
   endfunction

   // phase and bit counter; chip select high returns to command
   always_ff @(posedge sys_clk) begin
      if (!reset_n || !active) begin
         phase <= PH_CMD;
         bit_count <= `COUNT_ZERO;
         sel <= `SEL_STATUS;
      end else if (sclk_rise) begin
         unique case (phase)
            PH_CMD: begin
               if (bit_count == `COMMS_BITS - `COUNT_ONE) begin
                  bit_count <= `COUNT_ZERO;
                  sel <= cmd_sel;
                  phase <= in_shift[`COMMS_READ_BIT - 1]
                     ? PH_READ : PH_WRITE;
               end else
                  bit_count <= bit_count + `COUNT_ONE;
            end
            PH_WRITE, PH_READ: begin
               if (bit_count == width - `COUNT_ONE) begin
                  bit_count <= `COUNT_ZERO;
                  phase <= PH_CMD;
               end else
                  bit_count <= bit_count + `COUNT_ONE;
            end
         endcase
      end
   end

   // input shifter samples on the rising edge
   always_ff @(posedge sys_clk) begin
      if (!reset_n)
         in_shift <= `ZERO_WORD;
      else if (sclk_rise)
         in_shift <= {in_shift[22:0], link_s1.din};
   end

   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         out_shift <= `ZERO_WORD;
      end else if (phase == PH_CMD && sclk_rise
            && bit_count == `COMMS_BITS - `COUNT_ONE) begin
         out_shift <= reg_value(cmd_sel) << (`LONG_BITS - reg_bits(cmd_sel));
      end else if (phase == PH_READ && sclk_fall) begin
         out_shift <= {out_shift[22:0], 1'b0};
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         mode_reg <= `MODE_RESET;
         config_reg <= `CONFIG_RESET;
         gpo_reg <= `GPO_RESET;
      end else if (write_done) begin
         unique case (sel)
            `SEL_MODE: mode_reg <= {in_shift[22:0], link_s1.din};
            `SEL_CONFIG: config_reg <= {in_shift[22:0], link_s1.din};
            `SEL_GPOCON: gpo_reg <= {16'h0000, in_shift[6:0], link_s1.din};
            default: gpo_reg <= gpo_reg;
         endcase
      end
   end

   // ------------------------------------------------------------
   // result update and ready flag
   // ------------------------------------------------------------
   // updates wait for chip select high so a read is never torn
   assign buf_pop = buf_valid && rdy_n && link_s1.cs_n && sync_s;

   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         rdy_n <= 1'b1;
         data_reg <= `ZERO_WORD;
      end else if (!sync_s) begin
         rdy_n <= 1'b1;
      end else if (buf_pop) begin
         data_reg <= buf_mem[buf_rd];
         rdy_n <= 1'b0;
      end else if (buf_valid && !rdy_n && link_s1.cs_n) begin
         rdy_n <= 1'b1;
      end else if (read_done && sel == `SEL_DATA) begin
         rdy_n <= 1'b1;
      end
   end

   // pin shows data bit while reading, ready otherwise
   always_ff @(posedge sys_clk) begin
      if (!reset_n)
         dout_rdy <= 1'b1;
      else if (phase == PH_READ && active && sclk_fall)
         dout_rdy <= out_shift[23]; // msb leaves as the shifter moves on
      else if (phase != PH_READ || !active)
         dout_rdy <= rdy_n;
   end

   // ------------------------------------------------------------
   // general-purpose outputs
   // ------------------------------------------------------------
   pin_drive_s pin1, pin0;
   always_comb begin
      pin1.level = gpo_reg[1];
      pin0.level = gpo_reg[0];
      pin1.oe_n = config_reg[`CFG_REF_SELECT_BIT];
      pin0.oe_n = config_reg[`CFG_REF_SELECT_BIT];
   end

   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         gpo_bit3 <= 1'b0;
         gpo_bit2 <= 1'b0;
         gpo1_or_second_ref_pos <= 1'b0;
         gpo1_or_second_ref_pos_oe_n <= 1'b0;
         gpo0_or_second_ref_neg <= 1'b0;
         gpo0_or_second_ref_neg_oe_n <= 1'b0;
         reference_source_select <= 1'b0;
      end else begin
         gpo_bit3 <= gpo_reg[3];
         gpo_bit2 <= gpo_reg[2];
         gpo1_or_second_ref_pos <= pin1.level & !pin1.oe_n;
         gpo1_or_second_ref_pos_oe_n <= pin1.oe_n;
         gpo0_or_second_ref_neg <= pin0.level & !pin0.oe_n;
         gpo0_or_second_ref_neg_oe_n <= pin0.oe_n;
         reference_source_select <= config_reg[`CFG_REF_SELECT_BIT];
      end
   end

endmodule

// file: testbench/adc_serial_pins_asserts.sv
// concurrent checks on the converter pin block
module adc_serial_pins_chk (
   input wire logic sys_clk, // clock
   input wire logic reset_n, // reset
   input wire logic cs_n, // select pin
   input wire logic sync_n, // sync pin
   input wire logic sample_valid, // offered
   input wire logic sample_ready, // accepted
   input wire logic dout_rdy, // out / ready
   input wire logic filter_reset, // filter reset
   input wire logic modulator_reset, // mod reset
   input wire logic gpo_bit3, // output 3
   input wire logic gpo_bit2, // output 2
   input wire logic gpo1_or_second_ref_pos_oe_n, // enable 1
   input wire logic gpo0_or_second_ref_neg_oe_n, // enable 0
   input wire logic reference_source_select // second ref
);
   timeunit 1ns;
   timeprecision 1ps;
   // ----------------
   // one domain only
   // ----------------
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!reset_n);

   a_sync_holds: assert property (
      !sync_n [*5] |-> filter_reset)
      else $error("filter not held");
   a_resets_paired: assert property (
      filter_reset == modulator_reset)
      else $error("resets differ");
   a_sync_frees: assert property (
      (reset_n && sync_n) [*6] |-> !filter_reset)
      else $error("filter reset stuck");
   a_sync_ready_high: assert property (
      (!sync_n && cs_n) [*6] |-> dout_rdy)
      else $error("ready low under sync");
   a_result_falls: assert property (
      sample_valid && sample_ready && dout_rdy && cs_n && sync_n
      |-> ##[1:8] !dout_rdy)
      else $error("no ready fall");
   a_second_ref_frees: assert property (
      reference_source_select |->
      gpo1_or_second_ref_pos_oe_n && gpo0_or_second_ref_neg_oe_n)
      else $error("shared pins still driven");
   a_gpo_drives: assert property (
      !reference_source_select |->
      !gpo1_or_second_ref_pos_oe_n && !gpo0_or_second_ref_neg_oe_n)
      else $error("shared pins not driven");
   a_write_in_frame: assert property (
      $changed({gpo_bit3, gpo_bit2, reference_source_select})
      |-> !$past(cs_n, 6))
      else $error("register changed outside frame");
endmodule

bind adc_serial_pins adc_serial_pins_chk chk (.sys_clk(sys_clk),
   .reset_n(reset_n), .cs_n(cs_n), .sync_n(sync_n),
   .sample_valid(sample_valid), .sample_ready(sample_ready),
   .dout_rdy(dout_rdy), .filter_reset(filter_reset),
   .modulator_reset(modulator_reset), .gpo_bit3(gpo_bit3),
   .gpo_bit2(gpo_bit2),
   .gpo1_or_second_ref_pos_oe_n(gpo1_or_second_ref_pos_oe_n),
   .gpo0_or_second_ref_neg_oe_n(gpo0_or_second_ref_neg_oe_n),
   .reference_source_select(reference_source_select));

// file: testbench/host_model.sv
// host side model that drives the serial pins
module host_model (
   input wire logic sys_clk, // clock
   input wire logic dout_rdy, // out / ready pin
   output logic cs_n, // select, active low
   output logic sclk, // link clock, idles high
   output logic din // data to device
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      cs_n = 1'b1;
      sclk = 1'b1;
      din = 1'b0;
   end
   // select held on its own, used to stall updates
   task automatic hold(input logic v);
      @(posedge sys_clk) cs_n <= v;
   endtask
   // one frame, msb first, 160 ns link period
   task automatic xfer(input logic [31:0] bits, input int n,
         output logic [23:0] rd);
      rd = 24'h000000;
      @(posedge sys_clk) cs_n <= 1'b0;
      repeat (4) @(posedge sys_clk);
      for (int i = 0; i < n; i++) begin
         sclk <= 1'b0;
         din <= bits[31 - i];
         repeat (4) @(posedge sys_clk);
         sclk <= 1'b1;
         repeat (4) @(posedge sys_clk);
         if (i >= 8) rd = {rd[22:0], dout_rdy};
      end
      cs_n <= 1'b1;
      din <= ~din; // released line stops showing last bit
      repeat (4) @(posedge sys_clk);
   endtask
endmodule

// file: testbench/tb_adc_serial_pins.sv
// self-checking bench for the serial, ready and pin block
`include "adc_pins_map.svh"
module tb_adc_serial_pins import adc_pins_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   logic sys_clk = 1'b0;
   logic reset_n = 1'b0;
   logic sync_n = 1'b1;
   logic sample_valid = 1'b0;
   word_t sample_data = 24'h000000;
   logic cs_n, sclk, din, sample_ready, dout_rdy, filt, modr;
   logic g3, g2, pos, pos_oe_n, neg, neg_oe_n, ref_select;
   int bad_count = 0;
   int check_count = 0;
   word_t rd;

   always #10 sys_clk = ~sys_clk;

   host_model host (.sys_clk(sys_clk), .dout_rdy(dout_rdy),
      .cs_n(cs_n), .sclk(sclk), .din(din));
   adc_serial_pins uut (.sys_clk(sys_clk), .reset_n(reset_n),
      .cs_n(cs_n), .sclk(sclk), .din(din), .sync_n(sync_n),
      .sample_data(sample_data), .sample_valid(sample_valid),
      .sample_ready(sample_ready), .dout_rdy(dout_rdy),
      .filter_reset(filt), .modulator_reset(modr), .gpo_bit3(g3),
      .gpo_bit2(g2), .gpo1_or_second_ref_pos(pos),
      .gpo1_or_second_ref_pos_oe_n(pos_oe_n),
      .gpo0_or_second_ref_neg(neg),
      .gpo0_or_second_ref_neg_oe_n(neg_oe_n),
      .reference_source_select(ref_select));

   // ----------------
   // shared tasks
   // ----------------
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   task automatic check(input word_t got, input word_t exp);
      check_count++;
      if (got !== exp) begin
         bad_count++;
         $display("BAD t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   // short registers ride in the top byte of the data field
   task automatic access(input logic wr, input logic [2:0] sel,
         input word_t val);
      logic lng;
      lng = sel inside {`SEL_MODE, `SEL_CONFIG, `SEL_DATA};
      host.xfer({1'b0, ~wr, sel, 3'h0, lng ? val : {val[7:0],
         16'h0000}}, lng ? 32 : 16, rd);
   endtask
   task automatic wait_rdy(input logic lvl);
      int n = 0;
      while (dout_rdy !== lvl && n < 200) begin
         @(posedge sys_clk);
         n++;
      end
      check({23'h000000, dout_rdy}, {23'h000000, lvl});
      // a level that never came ends the run as a failure
      if (dout_rdy !== lvl) print_verdict();
   endtask
   // valid held until the buffer takes the word
   task automatic offer(input word_t w);
      int n = 0;
      @(posedge sys_clk);
      sample_data <= w;
      sample_valid <= 1'b1;
      do begin
         @(posedge sys_clk);
         n++;
      end while (sample_ready !== 1'b1 && n < 100);
      sample_valid <= 1'b0;
      check({23'h000000, sample_ready}, 24'h000001);
      if (sample_ready !== 1'b1) print_verdict();
   endtask
   function automatic word_t pins();
      return {15'h0000, g3, g2, pos, neg, pos_oe_n, neg_oe_n, ref_select,
         dout_rdy, filt};
   endfunction

   // ----------------
   // scenarios
   // ----------------
   task automatic t_reset();
      check(pins(), 24'h000002);
      access(1'b0, `SEL_MODE, 24'h000000);
      check(rd, `MODE_RESET);
      access(1'b0, `SEL_CONFIG, 24'h000000);
      check(rd, `CONFIG_RESET);
      access(1'b0, `SEL_ID, 24'h000000);
      check(rd, `ID_VALUE);
      $display("reset test done");
   endtask
   task automatic t_pins();
      access(1'b1, `SEL_GPOCON, 24'h00000A);
      check(pins(), 24'h000142);
      access(1'b0, `SEL_GPOCON, 24'h000000);
      check(rd, 24'h00000A);
      access(1'b1, `SEL_GPOCON, 24'h000005);
      access(1'b1, `SEL_CONFIG, `CONFIG_RESET | 24'h100000);
      check(pins(), 24'h00009E);
      access(1'b0, `SEL_CONFIG, 24'h000000);
      check(rd, `CONFIG_RESET | 24'h100000);
      access(1'b1, `SEL_CONFIG, `CONFIG_RESET);
      check(pins(), 24'h0000A2);
      $display("pin test done");
   endtask
   task automatic t_result();
      word_t falls = 24'h000000;
      logic prev = 1'b1;
      offer(24'h123456);
      wait_rdy(1'b0);
      access(1'b0, `SEL_DATA, 24'h000000);
      check(rd, 24'h123456);
      check(pins() & 24'h000002, 24'h000002);
      // status shows the ready flag back high once the result is read
      access(1'b0, `SEL_STATUS, 24'h000000);
      check(rd, 24'h000001 << `STATUS_RDY_BIT);
      // select held low stalls updates so both words queue
      host.hold(1'b0);
      offer(24'hA5A5A5);
      offer(24'h5A5A5A);
      repeat (2) @(posedge sys_clk);
      check({23'h000000, sample_ready}, 24'h000000);
      host.hold(1'b1);
      repeat (40) begin
         @(posedge sys_clk);
         if (prev === 1'b1 && dout_rdy === 1'b0) falls++;
         prev = dout_rdy;
      end
      check(falls, 24'h000002);
      access(1'b0, `SEL_DATA, 24'h000000);
      check(rd, 24'h5A5A5A);
      $display("result test done");
   endtask
   task automatic t_sync();
      offer(24'h0F0F0F);
      wait_rdy(1'b0);
      sync_n <= 1'b0;
      repeat (6) @(posedge sys_clk);
      check({21'h000000, dout_rdy, filt, modr}, 24'h000007);
      access(1'b0, `SEL_GPOCON, 24'h000000);
      check(rd, 24'h000005);
      sync_n <= 1'b1;
      repeat (6) @(posedge sys_clk);
      check({22'h000000, filt, modr}, 24'h000000);
      offer(24'h00FF00);
      wait_rdy(1'b0);
      $display("sync test done");
   endtask

   initial begin
      repeat (6) @(posedge sys_clk);
      reset_n <= 1'b1;
      repeat (6) @(posedge sys_clk);
      t_reset();
      t_pins();
      t_result();
      t_sync();
      print_verdict();
   end
endmodule
